// ---- usb_host_dev_model.sv ----
`timescale 1ns/1ps
module usb_host_dev_model (
	input  wire        i_ref_clk,
	input  wire        i_rst,
	input  wire        i_rx_ready,
	input  wire        i_slow,
	input  wire        i_pid1,
	input  wire [31:0] i_pattern,
	output reg         o_rx_valid,
	output wire [31:0] o_rx_word,
	output wire        o_rx_last,
	output wire        o_rx_pid1
);
	reg [1:0] n_r;
	// Two data words per IN packet; idle data shows the inverse pattern
	assign o_rx_word = o_rx_valid ? i_pattern + n_r : ~(i_pattern + n_r);
	assign o_rx_last = o_rx_valid && n_r == 2'd1;
	assign o_rx_pid1 = i_pid1;
	always @(posedge i_ref_clk) begin
		if (i_rst || !i_rx_ready || n_r == 2'd2) begin
			o_rx_valid <= 1'b0;
			n_r <= (i_rst || !i_rx_ready) ? 2'd0 : n_r;
		end else if (o_rx_valid) begin
			n_r <= n_r + 2'd1;
			o_rx_valid <= !i_slow && n_r == 2'd0;
		end else begin
			o_rx_valid <= 1'b1;
		end
	end
endmodule

// ---- usb_host_ep_defines.vh ----
// Summary of operation
// - SETUP/OUT data is sent only while transmit enable bit 6 is set; the token is issued either way.
// - IN data is accepted only while receive enable bit 3 is set.
// - Transmit disabled: no transmit buffer access whatever the buffer mode.
// - Transmit single mode: one 64-byte buffer at the transmit base.
// - Transmit double mode: toggle 0 selects first buffer, toggle 1 the next.
// - Receive disabled: no receive buffer write whatever the buffer mode.
// - Receive single mode: IN data stored in one 64-byte buffer at receive base.
// - Receive double mode: expected toggle 0 first buffer, 1 second buffer.
// - Only low 15 base address bits are used; the mask clears bits 1 to 0, so buffers are always 4-byte aligned.
// - Preamble enable bit 7 sends PRE before low-speed traffic through a hub.
// - Auto frame bit 6 makes SOF automatically; otherwise only on software request.
// - Token PID sent is token register bits 7 to 4.
// - Target endpoint addressed is token register bits 3 to 0.
// - Transaction done flag is set at the end of every host transaction.
// - Receive toggle gives expected data PID: 1 DATA1, 0 DATA0.
`ifndef USB_HOST_EP_DEFINES_VH
`define USB_HOST_EP_DEFINES_VH

`define ADDR_EP_MODE     4'h0
`define ADDR_RX_BASE     4'h1
`define ADDR_TX_BASE     4'h2
`define ADDR_AUX_SETUP   4'h3
`define ADDR_TOKEN       4'h4
`define ADDR_TX_COUNT    4'h5
`define ADDR_TOGGLE      4'h6
`define ADDR_STATUS      4'h7
`define ADDR_TX_DATA     4'h8
`define ADDR_RX_DATA     4'h9

`define BIT_TX_EN        6
`define BIT_TX_DBUF      4
`define BIT_RX_EN        3
`define BIT_RX_DBUF      0
`define BIT_PRE_EN       7
`define BIT_SOF_EN       6
`define BIT_SOF_MANUAL   0
`define BIT_TX_TOG       6
`define BIT_RX_TOG       7
`define BIT_DONE         0
`define BIT_BUSY         1

`define EP_MODE_MASK     8'h59
`define AUX_MASK         8'hC0
`define TOG_MASK         8'hC0
`define BASE_MASK        16'h7FFC
`define BUF_BYTES        16'h0040
`define MEM_WORDS        8192
`define MEM_AW           13
`define FIFO_WIDTH       32
`define FIFO_DEPTH       16
`define RESET_BYTE       8'h00
`define RESET_HALF       16'h0000
`define FRAME_TIME_NS    1000000
`define CLK_PERIOD_NS    5
`define FRAME_CYCLES     (`FRAME_TIME_NS / `CLK_PERIOD_NS)
`define PID_PRE          4'hC
`define PID_SOF          4'h5
`define PID_IN           4'h9

`endif

// ---- usb_host_ep_fifo.v ----
`timescale 1ns/1ps
module usb_host_ep_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             i_ref_clk,
	input  wire             i_rst,
	input  wire [WIDTH-1:0] i_wr_data,
	input  wire             i_wr_valid,
	output wire             o_wr_ready,
	output wire [WIDTH-1:0] o_rd_data,
	output wire             o_rd_valid,
	input  wire             i_rd_ready
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW:0]      wr_ptr_r;
	reg [AW:0]      rd_ptr_r;
	wire            full;
	wire            empty;
	assign full       = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty      = (wr_ptr_r == rd_ptr_r);
	assign o_wr_ready = ~full;
	assign o_rd_valid = ~empty;
	assign o_rd_data  = mem_r[rd_ptr_r[AW-1:0]];
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else begin
			if (i_wr_valid && !full) begin
				mem_r[wr_ptr_r[AW-1:0]] <= i_wr_data;
				wr_ptr_r                <= wr_ptr_r + 1'b1;
			end
			if (i_rd_ready && !empty)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

// ---- usb_host_ep_setup.v ----
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "usb_host_ep_defines.vh"
module usb_host_ep_setup #(
	parameter FRAME_CYCLES = `FRAME_CYCLES
) (
	input  wire        i_ref_clk,
	input  wire        i_rst,
	input  wire [3:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	input  wire        i_rx_valid,
	input  wire [31:0] i_rx_word,
	input  wire        i_rx_last,
	input  wire        i_rx_data_pid1,
	output reg         o_rx_ready,
	output reg         o_tok_valid,
	output reg  [3:0]  o_tok_pid,
	output reg  [3:0]  o_tok_endp,
	output reg         o_tok_preamble,
	output reg         o_tx_valid,
	output reg  [31:0] o_tx_word,
	output reg         o_tx_last,
	output reg         o_sof_pulse
);
	// ************************************************************
	// Register file
	// ************************************************************
	reg [7:0]  host_endpoint_mode_r;
	reg [15:0] host_rx_buffer_base_r;
	reg [15:0] host_tx_buffer_base_r;
	reg [7:0]  host_aux_setup_r;
	reg [7:0]  host_token_setup_r;
	reg [7:0]  tx_byte_count_r;
	reg [7:0]  toggle_r;
	reg        done_r;
	reg        access_r;
	reg [15:0] sw_mem_ptr_r;
	reg [31:0] mem_r [0:`MEM_WORDS-1];
	reg [31:0] mem_rd_r;

	// ************************************************************
	// Transaction engine state
	// ************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_TOK  = 3'h1;
	localparam ST_TXRD = 3'h2;
	localparam ST_TXW  = 3'h3;
	localparam ST_RX   = 3'h4;
	localparam ST_DONE = 3'h5;
	reg [2:0]  state_r;
	reg [2:0]  state_nxt;
	reg [15:0] ptr_r;
	reg [7:0]  left_r;
	reg        start_r;
	reg [31:0] frame_cnt_r;
	reg        sof_req_r;

	wire host_tx_endpoint_enable    = host_endpoint_mode_r[`BIT_TX_EN];
	wire host_tx_double_buffer_mode = host_endpoint_mode_r[`BIT_TX_DBUF];
	wire host_rx_endpoint_enable    = host_endpoint_mode_r[`BIT_RX_EN];
	wire host_rx_double_buffer_mode = host_endpoint_mode_r[`BIT_RX_DBUF];
	wire tx_data_toggle             = toggle_r[`BIT_TX_TOG];
	wire rx_expected_toggle         = toggle_r[`BIT_RX_TOG];
	wire [3:0] token_code_field     = host_token_setup_r[7:4];
	wire [3:0] target_endpoint_field = host_token_setup_r[3:0];
	wire is_in_token                = (token_code_field == `PID_IN);

	// Buffer start: base limited to valid bits, plus 64 when the toggle picks the back half
	function [15:0] buf_start;
		input [15:0] base;
		input        dbuf;
		input        tog;
		begin
			buf_start = (base & `BASE_MASK) + ((dbuf && tog) ? `BUF_BYTES : 16'h0000);
		end
	endfunction

	wire [15:0] tx_start = buf_start(host_tx_buffer_base_r, host_tx_double_buffer_mode,
		tx_data_toggle);
	wire [15:0] rx_start = buf_start(host_rx_buffer_base_r, host_rx_double_buffer_mode,
		rx_expected_toggle);
	wire [`MEM_AW-1:0] ptr_word = ptr_r[`MEM_AW+1:2];
	wire [`MEM_AW-1:0] sw_word  = sw_mem_ptr_r[`MEM_AW+1:2];

	// ************************************************************
	// Outgoing data FIFO
	// ************************************************************
	wire        fifo_wr_ready;
	wire [31:0] fifo_rd_data;
	wire        fifo_rd_valid;
	wire        fifo_rd_ready = ~o_tx_valid;
	reg         fifo_wr_valid;
	always @* begin
		fifo_wr_valid = (state_r == ST_TXW);
	end
	usb_host_ep_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (4)
	) u_tx_fifo (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_wr_data  (mem_rd_r),
		.i_wr_valid (fifo_wr_valid),
		.o_wr_ready (fifo_wr_ready),
		.o_rd_data  (fifo_rd_data),
		.o_rd_valid (fifo_rd_valid),
		.i_rd_ready (fifo_rd_ready)
	);
	reg last_pending_r;

	// ************************************************************
	// Next state
	// ************************************************************
	wire bus_busy = (state_r != ST_IDLE);
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (start_r) state_nxt = ST_TOK;
			ST_TOK: begin
				if (is_in_token)
					state_nxt = host_rx_endpoint_enable ? ST_RX : ST_DONE;
				else if (host_tx_endpoint_enable && left_r != 8'h00)
					state_nxt = ST_TXRD;
				else
					state_nxt = ST_DONE;
			end
			ST_TXRD: state_nxt = ST_TXW;
			ST_TXW: if (fifo_wr_ready)
				state_nxt = (left_r <= 8'h04) ? ST_DONE : ST_TXRD;
			ST_RX: if (i_rx_valid && i_rx_last) state_nxt = ST_DONE;
			ST_DONE: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// ************************************************************
	// Sequential logic
	// ************************************************************
	wire bus_wr = i_avs_write && !access_r;
	wire bus_rd = i_avs_read && !access_r;
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			host_endpoint_mode_r  <= `RESET_BYTE;
			host_rx_buffer_base_r <= `RESET_HALF;
			host_tx_buffer_base_r <= `RESET_HALF;
			host_aux_setup_r      <= `RESET_BYTE;
			host_token_setup_r    <= `RESET_BYTE;
			tx_byte_count_r       <= `RESET_BYTE;
			toggle_r              <= `RESET_BYTE;
			done_r                <= 1'b0;
			access_r              <= 1'b0;
			sw_mem_ptr_r          <= `RESET_HALF;
			mem_rd_r              <= 32'h00000000;
			o_avs_readdata        <= 32'h00000000;
			o_avs_waitrequest     <= 1'b1;
			state_r               <= ST_IDLE;
			ptr_r                 <= `RESET_HALF;
			left_r                <= `RESET_BYTE;
			start_r               <= 1'b0;
			frame_cnt_r           <= 32'h00000000;
			sof_req_r             <= 1'b0;
			o_rx_ready            <= 1'b0;
			o_tok_valid           <= 1'b0;
			o_tok_pid             <= 4'h0;
			o_tok_endp            <= 4'h0;
			o_tok_preamble        <= 1'b0;
			o_tx_valid            <= 1'b0;
			o_tx_word             <= 32'h00000000;
			o_tx_last             <= 1'b0;
			o_sof_pulse           <= 1'b0;
			last_pending_r        <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// Bus: one wait cycle, then the answer with waitrequest low
			access_r          <= (i_avs_read || i_avs_write) && !access_r;
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !access_r);
			start_r           <= 1'b0;
			sof_req_r         <= 1'b0;
			if (bus_wr) begin
				case (i_avs_address)
					`ADDR_EP_MODE:   host_endpoint_mode_r <= i_avs_writedata[7:0] & `EP_MODE_MASK;
					`ADDR_RX_BASE:   host_rx_buffer_base_r <= i_avs_writedata[15:0];
					`ADDR_TX_BASE:   host_tx_buffer_base_r <= i_avs_writedata[15:0];
					`ADDR_AUX_SETUP: begin
						host_aux_setup_r <= i_avs_writedata[7:0] & `AUX_MASK;
						sof_req_r        <= i_avs_writedata[`BIT_SOF_MANUAL];
					end
					`ADDR_TOKEN: begin
						host_token_setup_r <= i_avs_writedata[7:0];
						start_r            <= !bus_busy;
					end
					`ADDR_TX_COUNT:  tx_byte_count_r <= i_avs_writedata[7:0];
					`ADDR_TOGGLE:    toggle_r <= i_avs_writedata[7:0] & `TOG_MASK;
					`ADDR_TX_DATA: begin
						mem_r[sw_word] <= i_avs_writedata;
						sw_mem_ptr_r   <= sw_mem_ptr_r + 16'h0004;
					end
					`ADDR_RX_DATA:   sw_mem_ptr_r <= i_avs_writedata[15:0] & `BASE_MASK;
					default: ;
				endcase
			end
			if (bus_rd) begin
				case (i_avs_address)
					`ADDR_EP_MODE:   o_avs_readdata <= {24'h000000, host_endpoint_mode_r};
					`ADDR_RX_BASE:   o_avs_readdata <= {16'h0000, host_rx_buffer_base_r};
					`ADDR_TX_BASE:   o_avs_readdata <= {16'h0000, host_tx_buffer_base_r};
					`ADDR_AUX_SETUP: o_avs_readdata <= {24'h000000, host_aux_setup_r};
					`ADDR_TOKEN:     o_avs_readdata <= {24'h000000, host_token_setup_r};
					`ADDR_TX_COUNT:  o_avs_readdata <= {24'h000000, tx_byte_count_r};
					`ADDR_TOGGLE:    o_avs_readdata <= {24'h000000, toggle_r};
					`ADDR_STATUS:    o_avs_readdata <= {30'h0000000, bus_busy, done_r};
					`ADDR_RX_DATA: begin
						o_avs_readdata <= mem_r[sw_word];
						sw_mem_ptr_r   <= sw_mem_ptr_r + 16'h0004;
					end
					default:         o_avs_readdata <= 32'h00000000;
				endcase
			end
			// Done flag: write 1 clears, a new completion wins
			if (state_r == ST_DONE)
				done_r <= 1'b1;
			else if (bus_wr && i_avs_address == `ADDR_STATUS && i_avs_writedata[`BIT_DONE])
				done_r <= 1'b0;
			// Frame marker generation
			o_sof_pulse <= 1'b0;
			if (host_aux_setup_r[`BIT_SOF_EN]) begin
				if (frame_cnt_r >= FRAME_CYCLES - 1) begin
					frame_cnt_r <= 32'h00000000;
					o_sof_pulse <= 1'b1;
				end else
					frame_cnt_r <= frame_cnt_r + 32'h00000001;
			end else begin
				frame_cnt_r <= 32'h00000000;
				o_sof_pulse <= sof_req_r;
			end
			// Token issue
			o_tok_valid <= 1'b0;
			if (state_r == ST_TOK) begin
				o_tok_valid    <= 1'b1;
				o_tok_pid      <= token_code_field;
				o_tok_endp     <= target_endpoint_field;
				o_tok_preamble <= host_aux_setup_r[`BIT_PRE_EN];
				ptr_r          <= is_in_token ? rx_start : tx_start;
				left_r         <= is_in_token ? 8'h00 : tx_byte_count_r;
			end
			if (state_r == ST_IDLE && start_r)
				left_r <= tx_byte_count_r;
			// Transmit path: buffer to FIFO to link
			if (state_r == ST_TXRD)
				mem_rd_r <= mem_r[ptr_word];
			if (state_r == ST_TXW && fifo_wr_ready) begin
				ptr_r          <= ptr_r + 16'h0004;
				left_r         <= (left_r <= 8'h04) ? 8'h00 : left_r - 8'h04;
				last_pending_r <= 1'b1;
			end
			if (fifo_rd_valid && !o_tx_valid) begin
				o_tx_valid <= 1'b1;
				o_tx_word  <= fifo_rd_data;
				o_tx_last  <= (state_r == ST_DONE || state_r == ST_IDLE) && last_pending_r;
			end else
				o_tx_valid <= 1'b0;
			if (state_r == ST_IDLE && !fifo_rd_valid)
				last_pending_r <= 1'b0;
			// Receive path: store only with matching data PID
			o_rx_ready <= (state_nxt == ST_RX);
			if (state_r == ST_RX && i_rx_valid && o_rx_ready) begin
				if (i_rx_data_pid1 == rx_expected_toggle) begin
					mem_r[ptr_word] <= i_rx_word;
					ptr_r           <= ptr_r + 16'h0004;
				end
			end
		end
	end
endmodule

// ---- usb_host_ep_setup_properties.sv ----
`timescale 1ns/1ps
`include "usb_host_ep_defines.vh"
module usb_host_ep_setup_properties #(
	parameter FRAME_CYCLES = 20
) (
	input wire        i_ref_clk,
	input wire        i_rst,
	input wire [3:0]  i_avs_address,
	input wire        i_avs_read,
	input wire        i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire        o_avs_waitrequest,
	input wire        o_rx_ready,
	input wire        o_tok_valid,
	input wire [3:0]  o_tok_pid,
	input wire [3:0]  o_tok_endp,
	input wire        o_tok_preamble,
	input wire        o_tx_valid,
	input wire        o_sof_pulse
);
	// ****************************
	// Shadow of accepted writes
	// ****************************
	wire        wr_ok = i_avs_write && !o_avs_waitrequest;
	reg  [7:0]  mode_r;
	reg  [7:0]  aux_r;
	reg  [7:0]  tok_r;
	reg  [31:0] gap_r;
	reg  [31:0] man_r;
	always @(posedge i_ref_clk) begin
		if (i_rst || (wr_ok && i_avs_address == `ADDR_EP_MODE))
			mode_r <= i_rst ? 8'h00 : i_avs_writedata[7:0];
		if (i_rst || (wr_ok && i_avs_address == `ADDR_AUX_SETUP))
			aux_r <= i_rst ? 8'h00 : i_avs_writedata[7:0];
		if (i_rst || (wr_ok && i_avs_address == `ADDR_TOKEN))
			tok_r <= i_rst ? 8'h00 : i_avs_writedata[7:0];
		man_r <= i_rst ? 32'h00000100 : (wr_ok && i_avs_address == `ADDR_AUX_SETUP
			&& i_avs_writedata[0]) ? 32'h00000000 : man_r + 32'h00000001;
		gap_r <= (!i_rst && aux_r[6] && !o_sof_pulse) ? gap_r + 32'h00000001 : 32'h00000000;
	end
	// ****************************
	// Properties
	// ****************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_req_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|-> ##[1:2] !o_avs_waitrequest) else $error("bus request not answered");
	a_tok_code: assert property (o_tok_valid |-> o_tok_pid == tok_r[7:4])
		else $error("token code differs from token register");
	a_tok_endpoint: assert property (o_tok_valid |-> o_tok_endp == tok_r[3:0])
		else $error("endpoint differs from token register");
	a_tok_preamble: assert property (o_tok_valid |-> o_tok_preamble == aux_r[7])
		else $error("preamble flag differs from aux setup");
	a_tx_gate: assert property (o_tx_valid |-> mode_r[6] && o_tok_pid != `PID_IN)
		else $error("transmit word while transmit disabled");
	a_rx_gate: assert property (o_rx_ready |-> mode_r[3] && o_tok_pid == `PID_IN)
		else $error("receive ready while receive disabled");
	a_sof_auto: assert property (gap_r <= FRAME_CYCLES + 4)
		else $error("automatic frame marker missing");
	a_sof_manual: assert property (o_sof_pulse && !aux_r[6] |-> man_r < 8)
		else $error("frame marker without request");
endmodule

// ---- usb_host_ep_setup_tb.sv ----
`timescale 1ns/1ps
`include "usb_host_ep_defines.vh"
module usb_host_ep_setup_tb;
	reg         i_ref_clk       = 1'b0;
	reg         i_rst           = 1'b1;
	reg  [3:0]  i_avs_address   = 4'h0;
	reg         i_avs_read      = 1'b0;
	reg         i_avs_write     = 1'b0;
	reg  [31:0] i_avs_writedata = 32'h00000000;
	reg         slow            = 1'b0;
	reg         pid1            = 1'b0;
	reg  [31:0] pattern         = 32'h00000000;
	reg  [31:0] rd;
	reg  [31:0] lastq;
	reg  [31:0] txq [0:31];
	wire [31:0] o_avs_readdata, o_tx_word, i_rx_word;
	wire [3:0]  o_tok_pid, o_tok_endp;
	wire        o_avs_waitrequest, i_rx_valid, i_rx_last, i_rx_data_pid1, o_rx_ready;
	wire        o_tok_valid, o_tok_preamble, o_tx_valid, o_tx_last, o_sof_pulse;
	integer     err_total = 0;
	integer     n_tests   = 0;
	integer     cyc       = 0;
	integer     ntx       = 0;
	integer     sofs      = 0;
	integer     toks      = 0;
	integer     s;
	always #2.5 i_ref_clk = ~i_ref_clk;
	usb_host_ep_setup #(
		.FRAME_CYCLES (20)
	) uut (
		.i_ref_clk         (i_ref_clk),
		.i_rst             (i_rst),
		.i_avs_address     (i_avs_address),
		.i_avs_read        (i_avs_read),
		.i_avs_write       (i_avs_write),
		.i_avs_writedata   (i_avs_writedata),
		.o_avs_readdata    (o_avs_readdata),
		.o_avs_waitrequest (o_avs_waitrequest),
		.i_rx_valid        (i_rx_valid),
		.i_rx_word         (i_rx_word),
		.i_rx_last         (i_rx_last),
		.i_rx_data_pid1    (i_rx_data_pid1),
		.o_rx_ready        (o_rx_ready),
		.o_tok_valid       (o_tok_valid),
		.o_tok_pid         (o_tok_pid),
		.o_tok_endp        (o_tok_endp),
		.o_tok_preamble    (o_tok_preamble),
		.o_tx_valid        (o_tx_valid),
		.o_tx_word         (o_tx_word),
		.o_tx_last         (o_tx_last),
		.o_sof_pulse       (o_sof_pulse)
	);
	usb_host_dev_model dev (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rx_ready(o_rx_ready),
		.i_slow(slow), .i_pid1(pid1), .i_pattern(pattern), .o_rx_valid(i_rx_valid),
		.o_rx_word(i_rx_word), .o_rx_last(i_rx_last), .o_rx_pid1(i_rx_data_pid1));
	// ****************************
	// Monitor and timeout
	// ****************************
	always @(posedge i_ref_clk) begin
		cyc = cyc + 1;
		if (o_tx_valid === 1'b1) begin
			txq[ntx % 32] = o_tx_word;
			lastq[ntx % 32] = o_tx_last;
			ntx = ntx + 1;
		end
		sofs = sofs + (o_sof_pulse === 1'b1);
		toks = toks + (o_tok_valid === 1'b1);
		if (cyc == 20000) begin
			err_total = err_total + 1;
			give_verdict;
		end
	end
	// ****************************
	// Shared tasks
	// ****************************
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task bus(input wr, input [3:0] a, input [31:0] d);
		integer k;
		begin
			k = 0;
			@(posedge i_ref_clk);
			i_avs_address <= a;
			i_avs_write <= wr;
			i_avs_read <= !wr;
			i_avs_writedata <= d;
			@(posedge i_ref_clk);
			while (o_avs_waitrequest !== 1'b0 && k < 50) begin
				@(posedge i_ref_clk);
				k = k + 1;
			end
			check(k < 50, 1);
			rd = o_avs_readdata;
			i_avs_write <= 1'b0;
			i_avs_read <= 1'b0;
		end
	endtask
	task rdchk(input [3:0] a, input [31:0] exp);
		begin
			bus(0, a, 32'h00000000);
			check(rd, exp);
		end
	endtask
	task wait_done;
		integer k;
		begin
			k = 0;
			rd = 32'h00000000;
			while (rd[0] !== 1'b1 && k < 40) begin
				bus(0, `ADDR_STATUS, 32'h00000000);
				k = k + 1;
			end
			check(rd[0], 1);
			bus(1, `ADDR_STATUS, 32'h00000001);
		end
	endtask
	task run_tok(input [7:0] mode, input [7:0] tog, input [7:0] tok);
		begin
			bus(1, `ADDR_EP_MODE, mode);
			bus(1, `ADDR_TOGGLE, tog);
			ntx = 0;
			s = toks;
			bus(1, `ADDR_TOKEN, tok);
			wait_done;
			check(toks - s, 1);
			check({o_tok_pid, o_tok_endp}, tok);
		end
	endtask
	task tx_case(input [7:0] mode, input [7:0] tog, input [7:0] tok, input [31:0] w, input n);
		begin
			run_tok(mode, tog, tok);
			check(ntx, n ? 2 : 0);
			if (n) begin
				check(txq[0], w);
				check(txq[1], w + 32'h1);
				check(lastq[1:0], 2'b10);
			end
		end
	endtask
	task rx_case(input [7:0] mode, input [7:0] tog, input p, input [31:0] e0, input [31:0] e1);
		begin
			bus(1, `ADDR_RX_DATA, 32'h00000200);
			bus(1, `ADDR_TX_DATA, 32'h00000000);
			bus(1, `ADDR_RX_DATA, 32'h00000240);
			bus(1, `ADDR_TX_DATA, 32'h00000000);
			pid1 <= p;
			pattern <= pattern + 32'h00010000;
			run_tok(mode, tog, 8'h92);
			bus(1, `ADDR_RX_DATA, 32'h00000200);
			rdchk(`ADDR_RX_DATA, e0 ? pattern : 32'h0);
			bus(1, `ADDR_RX_DATA, 32'h00000240);
			rdchk(`ADDR_RX_DATA, e1 ? pattern : 32'h0);
		end
	endtask
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// ****************************
	// Scenarios
	// ****************************
	task test_regs;
		begin
			rdchk(`ADDR_EP_MODE, 32'h0);
			rdchk(`ADDR_AUX_SETUP, 32'h0);
			bus(1, `ADDR_EP_MODE, 32'hFF);
			rdchk(`ADDR_EP_MODE, 32'h59);
			bus(1, `ADDR_AUX_SETUP, 32'h3E);
			rdchk(`ADDR_AUX_SETUP, 32'h0);
			bus(1, 4'hF, 32'h12);
			rdchk(4'hF, 32'h0);
			$display("register test done");
		end
	endtask
	task test_tx;
		begin
			bus(1, `ADDR_RX_DATA, 32'h00000100);
			bus(1, `ADDR_TX_DATA, 32'h11110000);
			bus(1, `ADDR_TX_DATA, 32'h11110001);
			bus(1, `ADDR_RX_DATA, 32'h00000140);
			bus(1, `ADDR_TX_DATA, 32'h22220000);
			bus(1, `ADDR_TX_DATA, 32'h22220001);
			bus(1, `ADDR_TX_BASE, 32'h00008100);
			bus(1, `ADDR_TX_COUNT, 32'h00000008);
			tx_case(8'h40, 8'h40, 8'hD3, 32'h11110000, 1);
			tx_case(8'h50, 8'h40, 8'h15, 32'h22220000, 1);
			tx_case(8'h50, 8'h00, 8'h1F, 32'h11110000, 1);
			tx_case(8'h10, 8'h00, 8'h11, 32'h0, 0);
			$display("transmit test done");
		end
	endtask
	task test_rx;
		begin
			bus(1, `ADDR_RX_BASE, 32'h00008200);
			rx_case(8'h08, 8'h00, 0, 1, 0);
			slow <= 1'b1;
			rx_case(8'h09, 8'h80, 1, 0, 1);
			slow <= 1'b0;
			rx_case(8'h09, 8'h00, 0, 1, 0);
			rx_case(8'h09, 8'h80, 0, 0, 0);
			rx_case(8'h01, 8'h00, 0, 0, 0);
			$display("receive test done");
		end
	endtask
	task test_aux;
		begin
			bus(1, `ADDR_AUX_SETUP, 32'h80);
			run_tok(8'h40, 8'h00, 8'h12);
			check(o_tok_preamble, 1);
			bus(1, `ADDR_AUX_SETUP, 32'h00);
			run_tok(8'h40, 8'h00, 8'h12);
			check(o_tok_preamble, 0);
			s = sofs;
			bus(1, `ADDR_AUX_SETUP, 32'h01);
			repeat (10) @(posedge i_ref_clk);
			check(sofs - s, 1);
			bus(1, `ADDR_AUX_SETUP, 32'h40);
			s = sofs;
			repeat (100) @(posedge i_ref_clk);
			check((sofs - s) >= 4 && (sofs - s) <= 6, 1);
			bus(1, `ADDR_AUX_SETUP, 32'h00);
			repeat (5) @(posedge i_ref_clk);
			s = sofs;
			repeat (100) @(posedge i_ref_clk);
			check(sofs - s, 0);
			$display("aux setup test done");
		end
	endtask
	task test_reset;
		begin
			bus(1, `ADDR_EP_MODE, 32'hFF);
			bus(1, `ADDR_AUX_SETUP, 32'h80);
			i_rst <= 1'b1;
			repeat (5) @(posedge i_ref_clk);
			check(o_avs_waitrequest, 1);
			i_rst <= 1'b0;
			rdchk(`ADDR_EP_MODE, 32'h0);
			rdchk(`ADDR_AUX_SETUP, 32'h0);
			$display("reset test done");
		end
	endtask
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		test_regs;
		test_tx;
		test_rx;
		test_aux;
		test_reset;
		give_verdict;
	end
endmodule
bind usb_host_ep_setup usb_host_ep_setup_properties #(
	.FRAME_CYCLES (FRAME_CYCLES)
) chk (
	.i_ref_clk         (i_ref_clk),
	.i_rst             (i_rst),
	.i_avs_address     (i_avs_address),
	.i_avs_read        (i_avs_read),
	.i_avs_write       (i_avs_write),
	.i_avs_writedata   (i_avs_writedata),
	.o_avs_waitrequest (o_avs_waitrequest),
	.o_rx_ready        (o_rx_ready),
	.o_tok_valid       (o_tok_valid),
	.o_tok_pid         (o_tok_pid),
	.o_tok_endp        (o_tok_endp),
	.o_tok_preamble    (o_tok_preamble),
	.o_tx_valid        (o_tx_valid),
	.o_sof_pulse       (o_sof_pulse)
);
